// ===== dit_defs.svh
`ifndef DIT_DEFS_SVH
`define DIT_DEFS_SVH
// register indexes; byte address is four times the index
`define DIT_IDX_CTRL0   16'hff53
`define DIT_IDX_CMP0    16'hff54
`define DIT_IDX_CNT0    16'hff55
`define DIT_IDX_CTRL1   16'hff57
`define DIT_IDX_CMP1    16'hff58
`define DIT_IDX_CNT1    16'hff59
`define DIT_IDX_STAT    16'hff5a
`define DIT_IDX_IEN     16'hff5b
`define DIT_IDX_ICLR    16'hff5c
`define DIT_IDX_RUNBIT  16'hff5d
// control field positions
`define DIT_RUN_POS     7
`define DIT_SEL_HI      2
`define DIT_SEL_LO      1
// run bit access: mask bits sit above the value bits
`define DIT_RB_MASK_LO  8
// reset values
`define DIT_CTRL_RST    8'h00
`define DIT_CMP_RST     8'hff
`define DIT_CNT_RST     8'h00
// prescaler tap exponents per selection
`define DIT_T0_SH0      3'h2
`define DIT_T0_SH1      3'h4
`define DIT_T0_SH2      3'h6
`define DIT_T1_SH0      3'h1
`define DIT_T1_SH1      3'h5
`define DIT_T1_SH2      3'h7
`endif

// ===== dit_pkg.sv
`default_nettype none
package dit_pkg;
  typedef logic [7:0]  dit_byte_t;
  typedef logic [1:0]  dit_sel_t;
  typedef logic [6:0]  dit_pre_t;
  typedef logic [15:0] dit_idx_t;
endpackage
`default_nettype wire

// ===== dit_top.sv
// Contract
// [R01] Control bit 7 runs counter; clearing it stops and zeroes the counter.
// [R02] Timer zero clock select 00/01/10 divides main clock by 4/16/64.
// [R03] Timer one clock select 00/01/10 divides main clock by 2/32/128.
// [R04] Reset loads both control registers with zero.
// [R05] Control accepts whole-byte writes and single run-bit writes.
// [R06] Software changes clock select only while stopped.
// [R07] Start: stop, select clock, write compare, then set run.
// [R08] Counter equal to compare clears to zero and keeps counting.
// [R09] Interrupt request raised in the cycle the match clears counter.
// [R10] Period is (N+1) count clocks for N from 00 to ff.
// [R11] First match may be up to one count clock off.
// [R12] Software avoids setting clock select and run in one write.
// [R13] Compare is eight bits, byte written, any value, undefined at reset.
// [R14] Software writes compare only while the timer is stopped.
// [R15] Counter is byte readable and cleared by reset.
// [R16] Control bits 6..3 and 0 read zero and ignore writes.
// [R17] Running counter increments once per selected prescaler pulse.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dit_defs.svh"
module dit_top
  import dit_pkg::*;
#(
  parameter int TMR_W = 8
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [17:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // interrupts
  output var  logic [1:0]  o_interval_match_irq,
  output var  logic        o_irq
);

  if (TMR_W != 8) begin : g_chk
    $error("dit_top serves only 8-bit timers");
  end

  function automatic logic [2:0] tap_of(input logic t, input dit_sel_t s);
    logic [2:0] r;
    r = 3'h0;
    case ({t, s})
      3'b000:  r = `DIT_T0_SH0; // [R02]
      3'b001:  r = `DIT_T0_SH1; // [R02]
      3'b010:  r = `DIT_T0_SH2; // [R02]
      3'b100:  r = `DIT_T1_SH0; // [R03]
      3'b101:  r = `DIT_T1_SH1; // [R03]
      3'b110:  r = `DIT_T1_SH2; // [R03]
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // one pulse every 2**tap cycles; prohibited select gives none
  function automatic logic tick_of(input dit_pre_t p, input logic t, input dit_sel_t s);
    dit_pre_t m;
    m = 7'h7f >> (3'h7 - tap_of(t, s));
    return (s != 2'b11) && ((p & m) == m);
  endfunction

  dit_pre_t   pre_ff,  nxt_pre;
  logic [1:0] run_ff,  nxt_run;
  dit_sel_t   sel_ff   [2];
  dit_sel_t   nxt_sel  [2];
  dit_byte_t  cmp_ff   [2];
  dit_byte_t  nxt_cmp  [2];
  dit_byte_t  cnt_ff   [2];
  dit_byte_t  nxt_cnt  [2];
  logic [1:0] match_ff, nxt_match;
  logic [1:0] stat_ff,  nxt_stat;
  logic [1:0] ien_ff,   nxt_ien;
  logic        irq_ff,    nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [1:0]  tick;
  dit_idx_t    idx;
  logic        wr_en;
  logic        rd_setup;

  assign idx      = i_paddr[17:2];
  assign wr_en    = i_psel & i_penable & pready_ff & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign tick[0]  = tick_of(pre_ff, 1'b0, sel_ff[0]);
  assign tick[1]  = tick_of(pre_ff, 1'b1, sel_ff[1]);

  function automatic dit_byte_t ctrl_of(input logic r, input dit_sel_t s);
    return {r, 4'h0, s, 1'b0}; // [R16]
  endfunction

  always_comb begin
    nxt_pre   = pre_ff + 7'h01;                                   // [R11]
    nxt_run   = run_ff;
    nxt_ien   = ien_ff;
    nxt_match = 2'b00;
    nxt_stat  = stat_ff;
    for (int t = 0; t < 2; t++) begin
      nxt_sel[t] = sel_ff[t];
      nxt_cmp[t] = cmp_ff[t];
      nxt_cnt[t] = cnt_ff[t];
    end
    if (wr_en) begin
      if (idx == `DIT_IDX_CTRL0) begin
        nxt_run[0] = i_pwdata[`DIT_RUN_POS];                      // [R05]
        nxt_sel[0] = i_pwdata[`DIT_SEL_HI:`DIT_SEL_LO];           // [R02]
      end else if (idx == `DIT_IDX_CTRL1) begin
        nxt_run[1] = i_pwdata[`DIT_RUN_POS];                      // [R05]
        nxt_sel[1] = i_pwdata[`DIT_SEL_HI:`DIT_SEL_LO];           // [R03]
      end else if (idx == `DIT_IDX_CMP0) begin
        nxt_cmp[0] = i_pwdata[7:0];                               // [R13]
      end else if (idx == `DIT_IDX_CMP1) begin
        nxt_cmp[1] = i_pwdata[7:0];                               // [R13]
      end else if (idx == `DIT_IDX_IEN) begin
        nxt_ien = i_pwdata[1:0];
      end else if (idx == `DIT_IDX_ICLR) begin
        nxt_stat = stat_ff & ~i_pwdata[1:0];
      end else if (idx == `DIT_IDX_RUNBIT) begin
        for (int t = 0; t < 2; t++) begin
          if (i_pwdata[`DIT_RB_MASK_LO + t]) begin
            nxt_run[t] = i_pwdata[t];                             // [R05]
          end
        end
      end
    end
    for (int t = 0; t < 2; t++) begin
      if (!run_ff[t]) begin
        nxt_cnt[t] = 8'h00;                                       // [R01]
      end else if (tick[t]) begin
        if (cnt_ff[t] == cmp_ff[t]) begin                         // [R10]
          nxt_cnt[t]   = 8'h00;                                   // [R08]
          nxt_match[t] = 1'b1;                                    // [R09]
        end else begin
          nxt_cnt[t] = cnt_ff[t] + 8'h01;                         // [R17]
        end
      end
      if (nxt_match[t]) begin
        nxt_stat[t] = 1'b1;
      end
    end
    nxt_irq = |(nxt_stat & nxt_ien);
  end

  always_comb begin
    nxt_pready  = rd_setup;
    nxt_pslverr = 1'b0;
    nxt_prdata  = 32'h0000_0000;
    if (rd_setup) begin
      if (idx == `DIT_IDX_CTRL0) begin
        nxt_prdata[7:0] = ctrl_of(run_ff[0], sel_ff[0]);
      end else if (idx == `DIT_IDX_CTRL1) begin
        nxt_prdata[7:0] = ctrl_of(run_ff[1], sel_ff[1]);
      end else if (idx == `DIT_IDX_CMP0) begin
        nxt_prdata[7:0] = cmp_ff[0];
      end else if (idx == `DIT_IDX_CMP1) begin
        nxt_prdata[7:0] = cmp_ff[1];
      end else if (idx == `DIT_IDX_CNT0) begin
        nxt_prdata[7:0] = cnt_ff[0];                              // [R15]
      end else if (idx == `DIT_IDX_CNT1) begin
        nxt_prdata[7:0] = cnt_ff[1];                              // [R15]
      end else if (idx == `DIT_IDX_STAT) begin
        nxt_prdata[1:0] = stat_ff;
      end else if (idx == `DIT_IDX_IEN) begin
        nxt_prdata[1:0] = ien_ff;
      end else if (idx == `DIT_IDX_ICLR || idx == `DIT_IDX_RUNBIT) begin
        nxt_prdata = 32'h0000_0000;
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_ff     <= 7'h00;
      run_ff     <= 2'b00;                                        // [R04]
      sel_ff[0]  <= 2'b00;                                        // [R04]
      sel_ff[1]  <= 2'b00;                                        // [R04]
      cmp_ff[0]  <= `DIT_CMP_RST;
      cmp_ff[1]  <= `DIT_CMP_RST;
      cnt_ff[0]  <= `DIT_CNT_RST;                                 // [R15]
      cnt_ff[1]  <= `DIT_CNT_RST;                                 // [R15]
      match_ff   <= 2'b00;
      stat_ff    <= 2'b00;
      ien_ff     <= 2'b00;
      irq_ff     <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pre_ff     <= nxt_pre;
      run_ff     <= nxt_run;
      sel_ff     <= nxt_sel;
      cmp_ff     <= nxt_cmp;
      cnt_ff     <= nxt_cnt;
      match_ff   <= nxt_match;
      stat_ff    <= nxt_stat;
      ien_ff     <= nxt_ien;
      irq_ff     <= nxt_irq;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign o_prdata             = prdata_ff;
  assign o_pready             = pready_ff;
  assign o_pslverr            = pslverr_ff;
  assign o_interval_match_irq = match_ff;
  assign o_irq                = irq_ff;

  // checks
  AST_STOP_CLEARS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R01]
    !run_ff[0] |=> cnt_ff[0] == 8'h00)
    else $error("stopped timer zero counter not cleared");

  AST_RESET_CTRL: assert property (@(posedge i_sys_clk) // [R04]
    $fell(i_sys_rst) |-> run_ff == 2'b00 && sel_ff[0] == 2'b00 && sel_ff[1] == 2'b00)
    else $error("control not zero after reset");

  AST_T0_DIV4: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R02]
    (tick[0] && sel_ff[0] == 2'b00) ##1 (sel_ff[0] == 2'b00) [*4]
      |-> tick[0] && !$past(tick[0], 1) && !$past(tick[0], 2) && !$past(tick[0], 3))
    else $error("timer zero divide by four spacing wrong");

  AST_T1_DIV2: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R03]
    (tick[1] && sel_ff[1] == 2'b00) ##1 (sel_ff[1] == 2'b00) [*2]
      |-> tick[1] && !$past(tick[1]))
    else $error("timer one divide by two spacing wrong");

  AST_RUNBIT_KEEPS_SEL: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R05]
    wr_en && idx == `DIT_IDX_RUNBIT |=> $stable(sel_ff[0]) && $stable(sel_ff[1]))
    else $error("run bit write disturbed clock select");

  AST_MATCH_WRAP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R08]
    run_ff[1] && tick[1] && cnt_ff[1] == cmp_ff[1] |=> cnt_ff[1] == 8'h00 && match_ff[1])
    else $error("timer one match did not wrap");

  AST_IRQ_WITH_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R09]
    match_ff[0] |-> cnt_ff[0] == 8'h00 && $past(run_ff[0]) && $past(cnt_ff[0] == cmp_ff[0]))
    else $error("match request without counter clear");

  AST_COUNT_STEP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R17]
    run_ff[0] && !tick[0] |=> $stable(cnt_ff[0]))
    else $error("timer zero counted without a pulse");

  AST_COUNT_INC: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R17]
    run_ff[0] && tick[0] && cnt_ff[0] != cmp_ff[0] |=> cnt_ff[0] == $past(cnt_ff[0]) + 8'h01)
    else $error("timer zero did not increment");

  AST_CMP_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R13]
    wr_en && idx == `DIT_IDX_CMP0 |=> cmp_ff[0] == $past(i_pwdata[7:0]))
    else $error("compare write lost");

  AST_IRQ_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    match_ff[0] && ien_ff[0] |-> o_irq)
    else $error("enabled match did not raise interrupt");

  AST_STOP_CLEARS1: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R01]
    !run_ff[1] |=> cnt_ff[1] == 8'h00)
    else $error("stopped timer one counter not cleared");

  AST_RESET_COUNT: assert property (@(posedge i_sys_clk) // [R15]
    $fell(i_sys_rst) |-> cnt_ff[0] == 8'h00 && cnt_ff[1] == 8'h00)
    else $error("counter not zero after reset");

  AST_T0_SEL_REFUSED: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R02]
    sel_ff[0] == 2'b11 |-> !tick[0])
    else $error("timer zero pulsed on prohibited select");

  AST_T1_SEL_REFUSED: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R03]
    sel_ff[1] == 2'b11 |-> !tick[1])
    else $error("timer one pulsed on prohibited select");

  AST_CMP1_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R13]
    wr_en && idx == `DIT_IDX_CMP1 |=> cmp_ff[1] == $past(i_pwdata[7:0]))
    else $error("timer one compare write lost");

  AST_CTRL_UNUSED_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R16]
    o_pready && !i_pwrite && (idx == `DIT_IDX_CTRL0 || idx == `DIT_IDX_CTRL1)
      |-> o_prdata[6:3] == 4'h0 && o_prdata[0] == 1'b0 && o_prdata[31:8] == 24'h000000)
    else $error("unused control bits read nonzero");

  AST_READY_ONE_CYCLE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_pready |=> !o_pready)
    else $error("ready stood longer than one cycle");

  AST_ERR_WITH_READY: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_pslverr |-> o_pready)
    else $error("error response without ready");

  AST_STAT_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    match_ff[1] |-> stat_ff[1])
    else $error("timer one match not latched in status");

  COV_MATCH0: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) match_ff[0]);
  COV_MATCH1: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) match_ff[1]);
  COV_IRQ: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) $rose(o_irq));
  COV_ERR: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) o_pslverr);

endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dit_defs.svh"
module testbench;
  import dit_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [17:0] paddr   = 18'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  irq_v;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          n;
  int          sh[2][3]  = '{'{2, 4, 6}, '{1, 5, 7}};

  dit_top u_dut (
    .i_sys_clk            (sys_clk),
    .i_sys_rst            (sys_rst),
    .i_psel               (psel),
    .i_penable            (penable),
    .i_pwrite             (pwrite),
    .i_paddr              (paddr),
    .i_pwdata             (pwdata),
    .o_prdata             (prdata),
    .o_pready             (pready),
    .o_pslverr            (pslverr),
    .o_interval_match_irq (irq_v),
    .o_irq                (irq)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, starting one edge after the caller's edge
  task automatic apb(input logic wr, input dit_idx_t idx, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pulse(input int t);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq_v[t] !== 1'b1 && n < 2000);
  endtask

  task automatic run_cfg(input int t, input int s);
    dit_idx_t c;
    dit_idx_t cm;
    dit_idx_t cn;
    c  = t ? `DIT_IDX_CTRL1 : `DIT_IDX_CTRL0;
    cm = t ? `DIT_IDX_CMP1 : `DIT_IDX_CMP0;
    cn = t ? `DIT_IDX_CNT1 : `DIT_IDX_CNT0;
    apb(1'b1, c, 32'h0);
    apb(1'b1, c, 32'(s << 1));
    apb(1'b1, cm, 32'(s));
    apb(1'b1, `DIT_IDX_RUNBIT, t ? 32'h202 : 32'h101);
    apb(1'b0, c, 32'h0);
    chk(rd, 32'(8'h80 | (s << 1)));
    wait_pulse(t);
    wait_pulse(t);
    chk(32'(n), 32'((s + 1) << sh[t][s]));
    @(posedge sys_clk);
    chk(32'(irq_v[t]), 32'h0);
    apb(1'b0, cn, 32'h0);
    chk(32'(rd[7:0] <= 8'(s)), 32'h1);
    if (t == 0) apb(1'b1, `DIT_IDX_RUNBIT, 32'h100);
    else apb(1'b1, c, 32'(s << 1));
    apb(1'b0, c, 32'h0);
    chk(rd, 32'(s << 1));
    apb(1'b0, cn, 32'h0);
    chk(rd, 32'h0);
    $display("test timer %0d select %0d done", t, s);
  endtask

  initial begin
    dit_idx_t ri[5];
    ri = '{`DIT_IDX_CTRL0, `DIT_IDX_CTRL1, `DIT_IDX_CNT0, `DIT_IDX_CNT1, `DIT_IDX_STAT};
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (ri[i]) begin
      apb(1'b0, ri[i], 32'h0);
      chk(rd, 32'h0);
    end
    $display("test reset values done");
    apb(1'b1, `DIT_IDX_CTRL0, 32'hffff_ff7f);
    apb(1'b0, `DIT_IDX_CTRL0, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, `DIT_IDX_CTRL1, 32'h0000_007e);
    apb(1'b0, `DIT_IDX_CTRL1, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, `DIT_IDX_CTRL1, 32'h0);
    apb(1'b1, `DIT_IDX_CNT0, 32'hff);
    apb(1'b0, `DIT_IDX_CNT0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 16'hff60, 32'h1);
    chk(32'(er), 32'h1);
    apb(1'b0, 16'hff60, 32'h0);
    chk(32'(er), 32'h1);
    $display("test access kinds done");
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 3; s++) begin
        run_cfg(t, s);
      end
    end
    apb(1'b0, `DIT_IDX_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(32'(irq), 32'h0);
    apb(1'b1, `DIT_IDX_IEN, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `DIT_IDX_IEN, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, `DIT_IDX_IEN, 32'h3);
    apb(1'b1, `DIT_IDX_ICLR, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    apb(1'b0, `DIT_IDX_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire
